// ---- design/vbd_pkg.sv ----
// Constants, encodings and register map of the voice band DSP core.
// Assumes a single clock domain shared by both ends of the load link.
package vbd_pkg;
    localparam int DATA_W = 30;
    localparam int GUARD_W = 2;
    localparam int INT_W = 16;
    localparam int FRAC_W = 12;
    localparam int INSTR_W = 16;
    localparam int PC_W = 9;
    localparam int IMEM_WORDS = 512;
    localparam int DRAM_WORDS = 64;
    localparam int RA_W = 6;
    localparam int IFACE_W = 10;
    localparam int GAIN_W = 6;

    localparam logic [3:0] CSI_ADDR_RAM = 4'hD;
    localparam logic [1:0] SUB_LOW = 2'h0;
    localparam logic [1:0] SUB_HIGH = 2'h1;
    localparam logic [1:0] SUB_ADDR = 2'h2;
    localparam logic [1:0] SUB_IFACE = 2'h3;

    localparam logic [3:0] OP_LDA_M = 4'h0;
    localparam logic [3:0] OP_LDA_C = 4'h1;
    localparam logic [3:0] OP_STO = 4'h2;
    localparam logic [3:0] OP_RTN = 4'h3;
    localparam logic [3:0] OP_ADD_M = 4'h4;
    localparam logic [3:0] OP_ADD_C = 4'h5;
    localparam logic [3:0] OP_SUB_M = 4'h6;
    localparam logic [3:0] OP_SUB_C = 4'h7;
    localparam logic [3:0] OP_MUL_M = 4'h8;
    localparam logic [3:0] OP_MUL_C = 4'h9;
    localparam logic [3:0] OP_JMFS = 4'hA;
    localparam logic [3:0] OP_JMFC = 4'hB;
    localparam logic [3:0] OP_JSFS = 4'hC;
    localparam logic [3:0] OP_JSFC = 4'hD;
    localparam logic [3:0] OP_STF = 4'hE;
    localparam logic [3:0] OP_IDX = 4'hF;

    localparam logic [2:0] MODE_REG = 3'h0;
    localparam logic [2:0] MODE_REG_IDX = 3'h1;
    localparam logic [2:0] MODE_PORT = 3'h2;
    localparam logic [2:0] MODE_SMALL = 3'h3;
    localparam logic [2:0] MODE_INDEX = 3'h4;

    localparam logic [2:0] PORT_RX = 3'h0;
    localparam logic [2:0] PORT_TX = 3'h1;
    localparam logic [2:0] PORT_CSI = 3'h2;
    localparam logic [2:0] PORT_ZERO = 3'h3;
    localparam logic [2:0] PORT_TX_GAIN = 3'h4;
    localparam logic [2:0] PORT_RX_GAIN = 3'h5;
    localparam logic [2:0] PORT_RX_VOL = 3'h6;
    localparam logic [2:0] PORT_SIDE_GAIN = 3'h7;

    localparam logic [2:0] FLAG_USER_A = 3'h5;
    localparam logic [2:0] IM_STORE = 3'h0;
    localparam logic [2:0] IM_INC = 3'h1;
    localparam logic [2:0] IM_ACC = 3'h4;

    localparam logic [29:0] ACC_MAX = 30'h1FFFFFFF;
    localparam logic [29:0] ACC_MIN = 30'h20000000;
    localparam int COEFF_SHIFT = 11;

    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_LOAD = 12'h004;
    localparam logic [11:0] REG_IFACE = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00C;
    localparam int CTRL_TX_BIT = 0;
    localparam int CTRL_RX_BIT = 1;
    localparam int LOAD_DATA_LSB = 16;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_RUNNING_BIT = 2;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    typedef enum logic [1:0] {HS_IDLE, HS_HIGH, HS_LOW} vbd_host_state_t;
endpackage : vbd_pkg

// ---- design/vbd_if.sv ----
// Control serial link between the host controller and the DSP core.
// Assumes both ends run on the same pclk; no wire is two-way.
interface vbd_if;
    logic csi_wr;
    logic [3:0] csi_addr;
    logic [1:0] csi_sub;
    logic [9:0] csi_data;
    logic vb_tx_on;
    logic vb_rx_on;
    logic [9:0] proc_word;
    logic running;

    modport device (
        input csi_wr, csi_addr, csi_sub, csi_data, vb_tx_on, vb_rx_on,
        output proc_word, running
    );
    modport host (
        output csi_wr, csi_addr, csi_sub, csi_data, vb_tx_on, vb_rx_on,
        input proc_word, running
    );
endinterface : vbd_if

// ---- design/vbd_device.sv ----
// Voice band DSP core: instruction memory loader, decoder and datapath.
// Assumes the host writes the load window over the link and that the
// sample, gain and sync inputs are synchronous to pclk.
//
// The APB register port and the placing of the registers are this design's own decisions.
module vbd_device
    import vbd_pkg::*;
#(
    parameter int IMEM_DEPTH = IMEM_WORDS,
    parameter int DRAM_DEPTH = DRAM_WORDS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    vbd_if.device link,
    input wire logic [15:0] rx_sample_in,
    input wire logic [15:0] tx_sample_in,
    input wire logic [5:0] tx_gain,
    input wire logic [5:0] rx_gain,
    input wire logic [5:0] rx_volume,
    input wire logic [5:0] side_gain,
    input wire logic audio_frame_sync,
    output logic [15:0] rx_sample_out,
    output logic [15:0] tx_sample_out,
    output logic rx_out_stb,
    output logic tx_out_stb,
    output logic rx_in_stb,
    output logic tx_in_stb,
    output logic filter_reset
);
    logic [INSTR_W-1:0] imem [IMEM_DEPTH];
    logic [DATA_W-1:0] dram [DRAM_DEPTH];
    logic [PC_W-1:0] load_addr;
    logic [7:0] load_high;
    logic [IFACE_W-1:0] host_word;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] ret_pc;
    logic [DATA_W-1:0] acc;
    logic [RA_W-1:0] idx;
    logic [2:0] user_flags;
    logic [DATA_W-1:0] next_acc;
    logic [DATA_W-1:0] operand;
    logic [PC_W-1:0] next_pc;

    // Saturating narrow from the wide internal result to the accumulator.
    function automatic logic [DATA_W-1:0] sat(input logic signed [45:0] v);
        if (v > $signed({{16{1'b0}}, ACC_MAX})) begin
            sat = ACC_MAX;
        end else if (v < $signed({{16{1'b1}}, ACC_MIN})) begin
            sat = ACC_MIN;
        end else begin
            sat = v[DATA_W-1:0];
        end
    endfunction : sat

    // Load window decode.
    wire running = link.vb_tx_on | link.vb_rx_on;
    wire csi_hit = link.csi_wr && (link.csi_addr == CSI_ADDR_RAM);
    wire load_ok = csi_hit && !running;
    wire wr_addr = load_ok && (link.csi_sub == SUB_ADDR);
    wire wr_high = load_ok && (link.csi_sub == SUB_HIGH);
    wire wr_low = load_ok && (link.csi_sub == SUB_LOW);
    wire wr_iface = csi_hit && (link.csi_sub == SUB_IFACE);
    assign link.running = running;

    // Instruction fields; fetch is a plain read so each word retires
    // in the cycle it is addressed.
    wire [INSTR_W-1:0] instr = imem[pc];
    wire [3:0] opc = instr[15:12];
    wire [2:0] mode = instr[11:9];
    wire [8:0] dfield = instr[8:0];
    wire [11:0] coeff = instr[11:0];
    wire use_coeff = opc[0] && (opc <= OP_MUL_C) && (opc != OP_RTN);
    wire [RA_W-1:0] ra = (mode == MODE_REG_IDX) ?
        RA_W'(dfield[5:0] + idx) : dfield[5:0];
    wire [DATA_W-1:0] dram_rd = dram[ra];
    wire [DATA_W-1:0] coeff_val = {{17{coeff[11]}}, coeff, 1'b0};
    wire read_op = (opc <= OP_MUL_C) && (opc != OP_STO) && (opc != OP_RTN);
    wire port_rd = read_op && !use_coeff && (mode == MODE_PORT);

    // Flag vector: always, index non-zero, all zero, all one, sync, user.
    wire [7:0] flags = {user_flags, audio_frame_sync, &acc, ~|acc,
        |idx, 1'b1};
    wire flag_hit = flags[instr[11:9]] ^ opc[0];

    // The multiplier operand is the coefficient or the Q4.12 integer
    // slice of the addressed operand; the product is rescaled.
    wire signed [15:0] mul_b = use_coeff ?
        {{4{coeff[11]}}, coeff} : operand[27:12];
    wire signed [45:0] product = $signed(acc) * mul_b;
    wire signed [45:0] mul_scaled = use_coeff ?
        (product >>> COEFF_SHIFT) : (product >>> FRAC_W);
    wire [DATA_W-1:0] src = use_coeff ? coeff_val : operand;
    wire signed [45:0] sum = $signed(acc) + $signed(src);
    wire signed [45:0] diff = $signed(acc) - $signed(src);

    // Operand selection from the mode descriptor and the input ports.
    always_comb begin
        operand = '0;
        case (mode)
            MODE_REG, MODE_REG_IDX: operand = dram_rd;
            MODE_SMALL: operand = {{9{dfield[8]}}, dfield, 12'h000};
            MODE_INDEX: operand = {12'h000, idx, 12'h000};
            MODE_PORT: begin
                case (dfield[2:0])
                    PORT_RX: operand = {{2{rx_sample_in[15]}},
                        rx_sample_in, 12'h000};
                    PORT_TX: operand = {{2{tx_sample_in[15]}},
                        tx_sample_in, 12'h000};
                    PORT_CSI: operand = {{8{host_word[9]}}, host_word,
                        12'h000};
                    PORT_ZERO: operand = '0;
                    PORT_TX_GAIN: operand = {12'h000, tx_gain, 12'h000};
                    PORT_RX_GAIN: operand = {12'h000, rx_gain, 12'h000};
                    PORT_RX_VOL: operand = {12'h000, rx_volume, 12'h000};
                    default: operand = {12'h000, side_gain, 12'h000};
                endcase
            end
            default: operand = '0;
        endcase
    end

    // Decoder: twelve operations over sixteen opcodes.
    always_comb begin
        next_acc = acc;
        next_pc = PC_W'(pc + 1'b1);
        case (opc)
            OP_LDA_M, OP_LDA_C: next_acc = src;
            OP_ADD_M, OP_ADD_C: next_acc = sat(sum);
            OP_SUB_M, OP_SUB_C: next_acc = sat(diff);
            OP_MUL_M, OP_MUL_C: next_acc = sat(mul_scaled);
            OP_RTN: next_pc = ret_pc;
            OP_JMFS, OP_JMFC, OP_JSFS, OP_JSFC: begin
                if (flag_hit) begin
                    next_pc = dfield;
                end
            end
            default: next_acc = acc;
        endcase
    end

    // Instruction memory writes need no reset; the held high byte and the
    // new low byte go in together so a half-loaded word never lands.
    always_ff @(posedge pclk) begin
        if (ce && wr_low) begin
            imem[load_addr] <= {load_high, link.csi_data[7:0]};
        end
    end

    always_ff @(posedge pclk) begin
        if (ce && running && opc == OP_STO && mode != MODE_PORT) begin
            dram[ra] <= acc;
        end
    end

    // Load registers; the address only changes when written.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_addr <= '0;
            load_high <= '0;
            host_word <= '0;
        end else if (ce) begin
            if (wr_addr) begin
                load_addr <= link.csi_data[8:0];
            end
            if (wr_high) begin
                load_high <= link.csi_data[7:0];
            end
            if (wr_iface) begin
                host_word <= link.csi_data;
            end
        end
    end

    // Sequencer; it sits at address 0 while both sections are off, so
    // enabling either one starts the program from the top.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= '0;
            ret_pc <= '0;
        end else if (ce) begin
            if (!running) begin
                pc <= '0;
            end else begin
                pc <= next_pc;
                if ((opc == OP_JSFS || opc == OP_JSFC) && flag_hit) begin
                    ret_pc <= PC_W'(pc + 1'b1);
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= '0;
            idx <= '0;
            user_flags <= '0;
        end else if (ce && running) begin
            acc <= next_acc;
            if (opc == OP_STF && instr[11:9] >= FLAG_USER_A) begin
                user_flags[instr[10:9] - 2'h1] <= instr[0];
            end
            if (opc == OP_IDX) begin
                case (instr[11:9])
                    IM_STORE: idx <= dfield[5:0];
                    IM_INC: idx <= RA_W'(dfield[5:0] + idx);
                    IM_ACC: idx <= acc[17:12];
                    default: idx <= idx;
                endcase
            end
        end
    end

    // Output ports carry no buffer: a store overwrites the last value
    // and the strobe marks the cycle, so spacing is the program's job.
    wire sto_port = running && opc == OP_STO && mode == MODE_PORT;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sample_out <= '0;
            tx_sample_out <= '0;
            link.proc_word <= '0;
            rx_out_stb <= 1'b0;
            tx_out_stb <= 1'b0;
            rx_in_stb <= 1'b0;
            tx_in_stb <= 1'b0;
        end else if (ce) begin
            rx_out_stb <= sto_port && dfield[2:0] == PORT_RX;
            tx_out_stb <= sto_port && dfield[2:0] == PORT_TX;
            rx_in_stb <= running && port_rd && dfield[2:0] == PORT_RX;
            tx_in_stb <= running && port_rd && dfield[2:0] == PORT_TX;
            if (sto_port && dfield[2:0] == PORT_RX) begin
                rx_sample_out <= acc[27:12];
            end
            if (sto_port && dfield[2:0] == PORT_TX) begin
                tx_sample_out <= acc[27:12];
            end
            if (sto_port && dfield[2:0] == PORT_CSI) begin
                link.proc_word <= acc[21:12];
            end
        end
    end

    assign filter_reset = user_flags[2];
endmodule : vbd_device

// ---- design/vbd_host.sv ----
// Host controller: APB slave that powers the voice sections and turns a
// single word write into the three-write instruction load sequence.
// Assumes the device end sits on the same link and the same pclk.
module vbd_host
    import vbd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    vbd_if.host link
);
    vbd_host_state_t state;
    logic [8:0] word_addr;
    logic [15:0] word_data;
    logic refused;

    wire wr_en = psel && penable && pwrite && ce;
    wire rd_setup = psel && !penable && !pwrite;
    wire powered = link.vb_tx_on | link.vb_rx_on;
    wire busy = state != HS_IDLE;
    wire wr_ctrl = wr_en && paddr == REG_CTRL;
    wire wr_load = wr_en && paddr == REG_LOAD;
    wire wr_iface = wr_en && paddr == REG_IFACE;
    wire wr_status = wr_en && paddr == REG_STATUS;
    // Loads are refused while powered since the device would drop them.
    wire load_go = wr_load && !busy && !powered;
    wire load_bad = wr_load && (busy || powered);
    wire iface_go = wr_iface && !busy;

    wire [31:0] rd_mux =
        (paddr == REG_CTRL) ? {30'h0, link.vb_rx_on, link.vb_tx_on} :
        (paddr == REG_LOAD) ? {word_data, 7'h00, word_addr} :
        (paddr == REG_IFACE) ? {22'h0, link.proc_word} :
        (paddr == REG_STATUS) ? {29'h0, link.running, refused, busy} :
        32'h0;

    // Zero wait states; pready follows the clock enable so a frozen
    // block holds the master off instead of losing its access.
    assign pready = ce;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (ce && rd_setup) begin
            prdata <= rd_mux;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {link.vb_rx_on, link.vb_tx_on} <= CTRL_RESET;
            refused <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) begin
                link.vb_tx_on <= pwdata[CTRL_TX_BIT];
                link.vb_rx_on <= pwdata[CTRL_RX_BIT];
            end
            if (load_bad) begin
                refused <= 1'b1;
            end else if (wr_status && pwdata[ST_REFUSED_BIT]) begin
                refused <= 1'b0;
            end
        end
    end

    // Address, then high byte, then low byte, one link write per cycle;
    // the address is resent for every word because it never advances.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= HS_IDLE;
            word_addr <= '0;
            word_data <= '0;
            link.csi_wr <= 1'b0;
            link.csi_addr <= '0;
            link.csi_sub <= '0;
            link.csi_data <= '0;
        end else if (ce) begin
            link.csi_wr <= 1'b0;
            link.csi_addr <= CSI_ADDR_RAM;
            case (state)
                HS_IDLE: begin
                    if (load_go) begin
                        word_addr <= pwdata[8:0];
                        word_data <= pwdata[LOAD_DATA_LSB +: 16];
                        link.csi_wr <= 1'b1;
                        link.csi_sub <= SUB_ADDR;
                        link.csi_data <= {1'b0, pwdata[8:0]};
                        state <= HS_HIGH;
                    end else if (iface_go) begin
                        link.csi_wr <= 1'b1;
                        link.csi_sub <= SUB_IFACE;
                        link.csi_data <= pwdata[9:0];
                    end
                end
                HS_HIGH: begin
                    link.csi_wr <= 1'b1;
                    link.csi_sub <= SUB_HIGH;
                    link.csi_data <= {2'h0, word_data[15:8]};
                    state <= HS_LOW;
                end
                default: begin
                    link.csi_wr <= 1'b1;
                    link.csi_sub <= SUB_LOW;
                    link.csi_data <= {2'h0, word_data[7:0]};
                    state <= HS_IDLE;
                end
            endcase
        end
    end
endmodule : vbd_host

// ---- verification/vbd_assertions.sv ----
// Checker of the load link between the host end and the device end.
// Assumes it sees the plain link signals on pclk, reset active low.
module vbd_assertions
    import vbd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic csi_wr,
    input wire logic [3:0] csi_addr,
    input wire logic [1:0] csi_sub,
    input wire logic [9:0] csi_data,
    input wire logic vb_tx_on,
    input wire logic vb_rx_on,
    input wire logic [9:0] proc_word,
    input wire logic running
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wire logic ld_addr = csi_wr && csi_sub == SUB_ADDR;
    wire logic ld_high = csi_wr && csi_sub == SUB_HIGH;
    wire logic ld_low = csi_wr && csi_sub == SUB_LOW;
    wire logic ld_iface = csi_wr && csi_sub == SUB_IFACE;

    property p_run_level;
        running == (vb_tx_on | vb_rx_on);
    endproperty
    a_run_level: assert property (p_run_level)
        else $error("running does not follow the power levels");
    property p_addr_then_high;
        ld_addr |=> ld_high;
    endproperty
    a_addr_then_high: assert property (p_addr_then_high)
        else $error("address write not followed by high byte");
    property p_high_then_low;
        ld_high |=> ld_low;
    endproperty
    a_high_then_low: assert property (p_high_then_low)
        else $error("high byte not followed by low byte");
    property p_high_after_addr;
        ld_high |-> $past(ld_addr);
    endproperty
    a_high_after_addr: assert property (p_high_after_addr)
        else $error("high byte sent without a fresh address");
    property p_low_ends;
        ld_low |=> !(csi_wr && csi_sub != SUB_ADDR);
    endproperty
    a_low_ends: assert property (p_low_ends)
        else $error("extra write after the low byte");
    property p_window;
        csi_wr |-> csi_addr == CSI_ADDR_RAM;
    endproperty
    a_window: assert property (p_window)
        else $error("link write outside the load window");
    property p_no_load_running;
        ld_addr |-> !running;
    endproperty
    a_no_load_running: assert property (p_no_load_running)
        else $error("load started while a voice section is on");
    property p_word_hold;
        !running && !$past(running) |-> $stable(proc_word);
    endproperty
    a_word_hold: assert property (p_word_hold)
        else $error("interface word moved while the core is off");
    property p_iface_pulse;
        ld_iface |=> !csi_wr;
    endproperty
    a_iface_pulse: assert property (p_iface_pulse)
        else $error("interface word write is not a single pulse");
endmodule : vbd_assertions

// ---- verification/voice_band_dsp_core_tb.sv ----
// Testbench: APB master drives the host end, which loads and runs the
// device end; results are judged at the device sample ports, at filter_reset and through register reads.
// Assumes the package register map and zero-wait APB answers.
module voice_band_dsp_core_tb
    import vbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, ce, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd, prdata;
    logic pready, pslverr;
    logic [15:0] rx_sample_out, tx_sample_out, rx_sample_in;
    logic rx_out_stb, tx_out_stb, filter_reset, rx_in_stb;
    logic audio_frame_sync;
    int num_errors = 0;
    int compares = 0;

    vbd_if i_vbd_if ();
    vbd_host i_vbd_host (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(i_vbd_if.host));
    vbd_device i_vbd_device (.pclk(pclk), .presetn(presetn), .ce(ce),
        .link(i_vbd_if.device), .rx_sample_in(rx_sample_in),
        .tx_sample_in(16'h0F0F), .tx_gain(6'h11), .rx_gain(6'h22),
        .rx_volume(6'h0C), .side_gain(6'h3F),
        .audio_frame_sync(audio_frame_sync),
        .rx_sample_out(rx_sample_out), .tx_sample_out(tx_sample_out),
        .rx_out_stb(rx_out_stb), .tx_out_stb(tx_out_stb),
        .rx_in_stb(rx_in_stb), .tx_in_stb(), .filter_reset(filter_reset));
    vbd_assertions i_vbd_assertions (.pclk(pclk), .presetn(presetn),
        .csi_wr(i_vbd_if.csi_wr), .csi_addr(i_vbd_if.csi_addr),
        .csi_sub(i_vbd_if.csi_sub), .csi_data(i_vbd_if.csi_data),
        .vb_tx_on(i_vbd_if.vb_tx_on), .vb_rx_on(i_vbd_if.vb_rx_on),
        .proc_word(i_vbd_if.proc_word), .running(i_vbd_if.running));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t ns: got %h want %h", $time, got, exp);
        end
    endtask : check

    // The master never assumes a latency: it holds until pready is seen.
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic load(input logic [8:0] a, input logic [15:0] w);
        apb(1'b1, REG_LOAD, {w, 7'h00, a});
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
        end while (rd[ST_BUSY_BIT] !== 1'b0);
    endtask : load

    task automatic load_prog(input logic [15:0] p[$]);
        for (int i = 0; i < p.size(); i++) load(9'(i), p[i]);
    endtask : load_prog

    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic wait_out(input logic tx, output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while ((tx ? tx_out_stb : rx_out_stb) !== 1'b1);
    endtask : wait_out

    // The loop adds 255 every three cycles, so 2000 cycles overshoot the
    // clamp point by a wide margin; a wrapping sum would read otherwise.
    task automatic test_high_clamp;
        int n;
        load_prog('{16'h46FF, 16'h2400, 16'hA000});
        apb(1'b1, REG_CTRL, 32'h2);
        wait_out(1'b0, n);
        check(rx_sample_out, 16'h00FF);
        wait_out(1'b0, n);
        check(16'(n), 16'h0003);
        check(rx_sample_out, 16'h01FE);
        repeat (2000) @(posedge pclk);
        wait_out(1'b0, n);
        check(rx_sample_out, 16'hFFFF);
        wait_out(1'b0, n);
        check(rx_sample_out, 16'hFFFF);
    endtask : test_high_clamp

    task automatic test_refused;
        int n;
        load(9'h000, 16'h66FF);
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd[15:0], 16'h0006);
        apb(1'b1, REG_STATUS, 32'h2);
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd[15:0], 16'h0004);
        do_reset();
        apb(1'b1, REG_CTRL, 32'h1);
        wait_out(1'b0, n);
        check(rx_sample_out, 16'h00FF);
    endtask : test_refused

    task automatic test_low_clamp;
        int n;
        do_reset();
        load_prog('{16'h66FF, 16'h2401, 16'hA000});
        apb(1'b1, REG_CTRL, 32'h3);
        wait_out(1'b1, n);
        check(tx_sample_out, 16'hFF01);
        repeat (2000) @(posedge pclk);
        wait_out(1'b1, n);
        check(tx_sample_out, 16'h0000);
        wait_out(1'b1, n);
        check(tx_sample_out, 16'h0000);
    endtask : test_low_clamp

    task automatic test_iface;
        int n;
        do_reset();
        apb(1'b1, REG_IFACE, 32'h1A5);
        load_prog('{16'h0402, 16'h2402, 16'h0400, 16'h2401, 16'hEE01,
            16'hA005});
        apb(1'b1, REG_CTRL, 32'h2);
        wait_out(1'b1, n);
        check(tx_sample_out, 16'h1234);
        repeat (4) @(negedge pclk);
        check({15'h0, filter_reset}, 16'h0001);
        apb(1'b0, REG_IFACE, 32'h0);
        check(rd[15:0], 16'h01A5);
        apb(1'b0, 12'h010, 32'h0);
        check(rd[15:0], 16'h0000);
        apb(1'b0, REG_CTRL, 32'h0);
        check(rd[15:0], 16'h0002);
    endtask : test_iface

    // A one-cycle sync pulse must release the wait loop exactly once.
    task automatic test_sync;
        int k;
        int j;
        do_reset();
        load_prog('{16'h0400, 16'h9400, 16'hB802, 16'h2400, 16'h2400,
            16'h2400, 16'h2400, 16'hA007});
        apb(1'b1, REG_CTRL, 32'h2);
        k = 0;
        j = 0;
        repeat (20) begin
            @(negedge pclk);
            if (rx_out_stb === 1'b1) k++;
            if (rx_in_stb === 1'b1) j++;
        end
        check(16'(k), 16'h0000);
        check(16'(j), 16'h0001);
        @(posedge pclk);
        audio_frame_sync <= 1'b1;
        @(posedge pclk);
        audio_frame_sync <= 1'b0;
        k = 0;
        repeat (20) begin
            @(negedge pclk);
            if (rx_out_stb === 1'b1) k++;
        end
        check(16'(k), 16'h0004);
        check(rx_sample_out, 16'h091A);
    endtask : test_sync

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rx_sample_in = 16'h1234;
        audio_frame_sync = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        test_high_clamp();
        test_refused();
        test_low_clamp();
        test_iface();
        test_sync();
        tally_and_finish();
    end

    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        $display("wrong value at %0t ns: run timed out", $time);
        tally_and_finish();
    end
endmodule : voice_band_dsp_core_tb
